// >>> dspwg_acc_if.sv
// one register transfer request between the sequencer and the pin driver
// assumes a single clock shared by both ends
`default_nettype none

interface dspwg_acc_if;
  logic        start;
  logic        wr;
  logic [1:0]  size;
  logic [15:0] addr;
  logic [31:0] wdata;
  logic        done;
  logic [31:0] rdata;

  modport seq (output start, output wr, output size, output addr, output wdata,
               input done, input rdata);
  modport drv (input start, input wr, input size, input addr, input wdata,
               output done, output rdata);
endinterface

`default_nettype wire

// >>> dspwg_dev_model.sv
// behavioural measurement device: register port, guarded data memory, run and done flag
// assumes the host holds each request until the cycle after regAck
`default_nettype none

module dspwg_dev_model #(
  parameter int PASS_CYC = 400
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  ackDelay,
  input  wire logic        regReq,
  input  wire logic        regWr,
  input  wire logic [1:0]  regSize,
  input  wire logic [15:0] regAddr,
  input  wire logic [31:0] regWdata,
  output var  logic        regAck,
  output var  logic [31:0] regRdata,
  output var  logic        firstRequestPin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // phase A mean-absolute result; the address is this model's own choice
  localparam logic [15:0] MAV_ADDR = 16'hE530;
  // ==========================================================
  // state
  logic [27:0] dm [0:62];
  logic [31:0] energy [0:4];
  logic [15:0] run, cfg, pa0, pa1;
  logic [27:0] pd0, pd1;
  logic [31:0] mask, rd;
  logic        doneFlag, prot, keyOk, served, pv0, pv1;
  int          waitCnt, passCnt;
  wire         inDm = regAddr >= dspwg_pkg::DM_FIRST && regAddr <= dspwg_pkg::DM_LAST;
  wire         inEn = regAddr >= dspwg_pkg::ENERGY_ADDR[0] && regAddr <= dspwg_pkg::ENERGY_ADDR[4];

  // ==========================================================
  // one register access, carried out at the acknowledge edge
  task automatic access();
    if (regWr && regAddr == dspwg_pkg::CTL_ADDR && keyOk) begin
      if (regWdata[7:0] == dspwg_pkg::CTL_PROT) prot = 1'b1;
      if (regWdata[7:0] == dspwg_pkg::CTL_UNPROT) prot = 1'b0;
    end else if (regWr && inDm) begin
      // protected writes vanish with no error sign; running does not matter
      if (!prot) begin
        // two-stage pipe: a word lands only after two later writes
        if (pv1) dm[pa1 - dspwg_pkg::DM_FIRST] = pd1;
        {pa1, pd1, pv1} = {pa0, pd0, pv0};
        {pa0, pd0, pv0} = {regAddr, regWdata[27:0], 1'b1};
      end
    end else if (regWr) begin
      case (regAddr)
        dspwg_pkg::RUN_ADDR: run = regWdata[15:0];
        dspwg_pkg::STATUS_ADDR: if (regWdata[17]) doneFlag = 1'b0;
        dspwg_pkg::MASK_ADDR: mask = regWdata;
        dspwg_pkg::CFG_ADDR: cfg = regWdata[15:0];
        default: ;
      endcase
    end else if (inDm) begin
      rd = {dspwg_pkg::DM_PAD, dm[regAddr - dspwg_pkg::DM_FIRST]};
    end else if (inEn) begin
      rd = energy[regAddr - dspwg_pkg::ENERGY_ADDR[0]];
      energy[regAddr - dspwg_pkg::ENERGY_ADDR[0]] = 32'h0;
    end else begin
      case (regAddr)
        dspwg_pkg::RMSA_ADDR: rd = {8'h00, 24'h3FF6A6};
        MAV_ADDR: rd = {12'h000, 20'h33316};
        dspwg_pkg::RUN_ADDR: rd = {16'h0000, run};
        dspwg_pkg::STATUS_ADDR: rd = {14'h0000, doneFlag, 17'h00000};
        dspwg_pkg::MASK_ADDR: rd = mask;
        default: rd = 32'h0;
      endcase
    end
    keyOk = regWr && regAddr == dspwg_pkg::KEY_ADDR && regSize == dspwg_pkg::SZ8
            && regWdata[7:0] == dspwg_pkg::KEY_VAL;
  endtask

  // ==========================================================
  // computation passes and the acknowledge timer
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      run = 16'h0000;
      prot = 1'b0;
      for (int i = 0; i < 63; i++) dm[i] = 28'h0;
      for (int i = 0; i < 5; i++) energy[i] = 32'h0;
      {cfg, mask, doneFlag, keyOk, served, pv0, pv1} = '0;
      waitCnt = 0;
      passCnt = 0;
      regAck <= 1'b0;
      regRdata <= 32'h0;
      firstRequestPin_n <= 1'b1;
    end else begin
      regAck <= 1'b0;
      // released data toggles every cycle between the last answer and its inverse
      regRdata <= ~regRdata;
      if (run == dspwg_pkg::RUN_GO) passCnt++;
      if (passCnt >= PASS_CYC) begin
        passCnt = 0;
        doneFlag = 1'b1;
        for (int i = 0; i < 5; i++) energy[i] = energy[i] + 32'h1;
      end
      if (!regReq) begin
        served = 1'b0;
        waitCnt = 0;
      end else if (!served && waitCnt < int'(ackDelay)) begin
        waitCnt++;
      end else if (!served) begin
        served = 1'b1;
        access();
        regAck <= 1'b1;
        regRdata <= rd;
      end
      // registered so the host never sees the pin move inside the clock edge
      firstRequestPin_n <= !(doneFlag && mask[dspwg_pkg::DONE_BIT]);
    end
  end
endmodule // dspwg_dev_model

`default_nettype wire

// >>> dspwg_host.sv
// host controller: starts and stops the measurement processor, guards its data
// memory with the keyed protection and acknowledges each computation-done event
// assumes the device register port of dspwg_xfer and a level request pin
`default_nettype none

module dspwg_host (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire logic                  cmdValid,
  input  wire dspwg_pkg::dspwg_op_e  cmdOp,
  input  wire logic [15:0]           cmdAddr,
  input  wire logic [31:0]           cmdData,
  input  wire logic [3:0][27:0]      gainVal,
  input  wire logic [15:0]           cfModeVal,
  input  wire logic                  lowPowerReq,
  output var  logic                  cmdReady,
  output var  logic                  cmdDone,
  output var  logic                  cmdErr,
  output var  logic [31:0]           rdData,
  output var  logic [23:0]           phaseACurrentRms,
  output var  logic                  dataReady,
  output var  logic                  running,
  output var  logic                  protOn,
  output var  logic                  regReq,
  output var  logic                  regWr,
  output var  logic [1:0]            regSize,
  output var  logic [15:0]           regAddr,
  output var  logic [31:0]           regWdata,
  input  wire logic                  regAck,
  input  wire logic [31:0]           regRdata,
  input  wire logic                  firstRequestPin_n
);
  typedef enum logic [3:0] {
    S_IDLE, S_GAIN, S_RUN, S_DMW, S_MASK, S_ENRD, S_CFG, S_KEY, S_CTL,
    S_VRD, S_ACK, S_RMS, S_RD, S_STOP, S_DONE
  } dspwg_st_e;
  typedef enum logic [1:0] {Q_INIT, Q_FIX, Q_USER} dspwg_seq_e;

  typedef struct packed {
    dspwg_st_e   st;
    dspwg_seq_e  seq;
    logic        wait_;
    logic        xStart;
    logic        xWr;
    logic [1:0]  xSize;
    logic [15:0] xAddr;
    logic [31:0] xData;
    logic [15:0] prevAddr;
    logic [2:0]  idx;
    logic [1:0]  cnt;
    logic [15:0] dmAddr;
    logic [27:0] dmData;
    logic        prot;
    logic        protTgt;
    logic        running;
    logic        halted;
    logic        retried;
    logic        rdy;
    logic        done;
    logic        err;
    logic [31:0] rdData;
    logic [23:0] rms;
    logic        dataRdy;
  } dspwg_host_s;

  dspwg_host_s s_r, s_nxt;
  dspwg_acc_if acc ();
  logic        fin;
  logic        issue;
  logic        xw;
  logic [1:0]  xs;
  logic [15:0] xa;
  logic [31:0] xd;

  function automatic logic inDm(input logic [15:0] a);
    return a >= dspwg_pkg::DM_FIRST && a <= dspwg_pkg::DM_LAST;
  endfunction

  // ==========================================================
  // sequencer: one register transfer at a time, advance on completion
  always_comb begin
    s_nxt         = s_r;
    s_nxt.done    = 1'b0;
    s_nxt.err     = 1'b0;
    s_nxt.dataRdy = 1'b0;
    s_nxt.xStart  = 1'b0;
    fin   = s_r.wait_ && acc.done;
    issue = 1'b1;
    xa    = dspwg_pkg::RUN_ADDR;
    xd    = '0;
    xw    = 1'b1;
    xs    = dspwg_pkg::SZ32;
    if (fin) begin
      s_nxt.wait_ = 1'b0;
    end
    unique case (s_r.st)
      S_IDLE: begin
        issue = 1'b0;
        if (cmdValid) begin
          s_nxt.dmAddr = cmdAddr;
          s_nxt.dmData = cmdData[dspwg_pkg::DM_BITS-1:0];
          s_nxt.seq    = Q_USER;
          s_nxt.idx    = '0;
          s_nxt.cnt    = '0;
          unique case (cmdOp)
            dspwg_pkg::OP_INIT: begin
              // init belongs right after reset; a stopped part needs reset first
              if (s_r.running || s_r.halted || !inDm(cmdAddr)) begin
                s_nxt.err = 1'b1;
              end else begin
                s_nxt.seq     = Q_INIT;
                s_nxt.retried = 1'b0;
                s_nxt.st      = S_GAIN;
              end
            end
            dspwg_pkg::OP_START: begin
              if (s_r.running) s_nxt.err = 1'b1;
              else s_nxt.st = S_RUN;
            end
            dspwg_pkg::OP_STOP:    s_nxt.st = S_STOP;
            dspwg_pkg::OP_DMWRITE: begin
              // refused rather than lost: protected, or changed while halted
              if (!inDm(cmdAddr) || s_r.prot || s_r.halted) s_nxt.err = 1'b1;
              else s_nxt.st = S_DMW;
            end
            dspwg_pkg::OP_READ:    s_nxt.st = S_RD;
            dspwg_pkg::OP_PROTECT: begin
              s_nxt.protTgt = 1'b1;
              s_nxt.st      = S_KEY;
            end
            dspwg_pkg::OP_UNPROTECT: begin
              s_nxt.protTgt = 1'b0;
              s_nxt.st      = S_KEY;
            end
            default: s_nxt.err = 1'b1;
          endcase
        end else if (!firstRequestPin_n) begin
          s_nxt.st = S_ACK;
        end else if (lowPowerReq && s_r.running) begin
          s_nxt.st = S_STOP;
        end
      end
      S_GAIN: begin
        xa = dspwg_pkg::GAIN_ADDR[s_r.idx[1:0]];
        xd = {dspwg_pkg::DM_PAD, gainVal[s_r.idx[1:0]]};
        if (fin) begin
          s_nxt.idx = s_r.idx + 3'h1;
          if (s_r.idx == dspwg_pkg::GAIN_LAST) s_nxt.st = S_RUN;
        end
      end
      S_RUN: begin
        xd = {16'h0000, dspwg_pkg::RUN_GO};
        xs = dspwg_pkg::SZ16;
        if (fin) begin
          s_nxt.running = 1'b1;
          s_nxt.halted  = 1'b0;
          s_nxt.st      = (s_r.seq == Q_INIT) ? S_DMW : S_DONE;
        end
      end
      S_DMW: begin
        xa = s_r.dmAddr;
        xd = {dspwg_pkg::DM_PAD, s_r.dmData};
        if (fin) begin
          s_nxt.cnt = s_r.cnt + 2'h1;
          // pipeline in the device needs the same word written three times
          if (s_r.cnt == dspwg_pkg::DM_LAST_CNT) begin
            s_nxt.cnt = '0;
            unique case (s_r.seq)
              Q_INIT:  s_nxt.st = S_MASK;
              Q_FIX:   begin
                s_nxt.protTgt = 1'b1;
                s_nxt.st      = S_KEY;
              end
              Q_USER:  s_nxt.st = S_DONE;
              default: s_nxt.st = S_DONE;
            endcase
          end
        end
      end
      S_MASK: begin
        xa = dspwg_pkg::MASK_ADDR;
        xd = dspwg_pkg::DONE_MASK;
        if (fin) begin
          s_nxt.idx = '0;
          s_nxt.st  = S_ENRD;
        end
      end
      S_ENRD: begin
        xa = dspwg_pkg::ENERGY_ADDR[s_r.idx];
        xw = 1'b0;
        if (fin) begin
          s_nxt.idx = s_r.idx + 3'h1;
          if (s_r.idx == dspwg_pkg::ENERGY_LAST) s_nxt.st = S_CFG;
        end
      end
      S_CFG: begin
        xa = dspwg_pkg::CFG_ADDR;
        xs = dspwg_pkg::SZ16;
        xd = {16'h0000, cfModeVal & ~dspwg_pkg::PD_MASK};
        if (fin) begin
          s_nxt.protTgt = 1'b1;
          s_nxt.st      = S_KEY;
        end
      end
      S_KEY: begin
        xa = dspwg_pkg::KEY_ADDR;
        xs = dspwg_pkg::SZ8;
        xd = {24'h000000, dspwg_pkg::KEY_VAL};
        if (fin) s_nxt.st = S_CTL;
      end
      S_CTL: begin
        xa = dspwg_pkg::CTL_ADDR;
        xs = dspwg_pkg::SZ8;
        xd = {24'h000000, s_r.protTgt ? dspwg_pkg::CTL_PROT : dspwg_pkg::CTL_UNPROT};
        if (fin) begin
          s_nxt.prot = s_r.protTgt;
          unique case (s_r.seq)
            Q_INIT:  s_nxt.st = S_VRD;
            Q_FIX:   s_nxt.st = s_r.protTgt ? S_DONE : S_DMW;
            Q_USER:  s_nxt.st = S_DONE;
            default: s_nxt.st = S_DONE;
          endcase
        end
      end
      S_VRD: begin
        xa = s_r.dmAddr;
        xw = 1'b0;
        if (fin) begin
          s_nxt.st = S_DONE;
          if (acc.rdata[dspwg_pkg::DM_BITS-1:0] != s_r.dmData) begin
            if (s_r.retried) begin
              s_nxt.err = 1'b1;
              s_nxt.st  = S_IDLE;
            end else begin
              s_nxt.retried = 1'b1;
              s_nxt.seq     = Q_FIX;
              s_nxt.protTgt = 1'b0;
              s_nxt.st      = S_KEY;
            end
          end
        end
      end
      S_ACK: begin
        xa = dspwg_pkg::STATUS_ADDR;
        xd = dspwg_pkg::DONE_MASK;
        if (fin) s_nxt.st = S_RMS;
      end
      S_RMS: begin
        xa = dspwg_pkg::RMSA_ADDR;
        xw = 1'b0;
        if (fin) begin
          s_nxt.rms     = acc.rdata[dspwg_pkg::RMS_BITS-1:0];
          s_nxt.dataRdy = 1'b1;
          s_nxt.st      = S_IDLE;
        end
      end
      S_RD: begin
        xa = s_r.dmAddr;
        xw = 1'b0;
        if (fin) begin
          s_nxt.rdData = acc.rdata;
          s_nxt.st     = S_DONE;
        end
      end
      S_STOP: begin
        xd = {16'h0000, dspwg_pkg::RUN_HALT};
        xs = dspwg_pkg::SZ16;
        if (fin) begin
          s_nxt.running = 1'b0;
          s_nxt.halted  = 1'b1;
          s_nxt.st      = S_DONE;
        end
      end
      S_DONE: begin
        issue      = 1'b0;
        s_nxt.done = 1'b1;
        s_nxt.st   = S_IDLE;
      end
      default: begin
        issue    = 1'b0;
        s_nxt.st = S_IDLE;
      end
    endcase
    if (issue && !s_r.wait_) begin
      s_nxt.xStart   = 1'b1;
      s_nxt.wait_    = 1'b1;
      s_nxt.xAddr    = xa;
      s_nxt.xData    = xd;
      s_nxt.xWr      = xw;
      s_nxt.xSize    = xs;
      s_nxt.prevAddr = s_r.xAddr;
    end
    s_nxt.rdy = (s_nxt.st == S_IDLE);
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign acc.start        = s_r.xStart;
  assign acc.wr           = s_r.xWr;
  assign acc.size         = s_r.xSize;
  assign acc.addr         = s_r.xAddr;
  assign acc.wdata        = s_r.xData;
  assign cmdReady         = s_r.rdy;
  assign cmdDone          = s_r.done;
  assign cmdErr           = s_r.err;
  assign rdData           = s_r.rdData;
  assign phaseACurrentRms = s_r.rms;
  assign dataReady        = s_r.dataRdy;
  assign running          = s_r.running;
  assign protOn           = s_r.prot;

  dspwg_xfer u_xfer (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .acc      (acc.drv),
    .regReq   (regReq),
    .regWr    (regWr),
    .regSize  (regSize),
    .regAddr  (regAddr),
    .regWdata (regWdata),
    .regAck   (regAck),
    .regRdata (regRdata)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  sequence gainLastDone;
    s_r.st == S_GAIN && fin && s_r.idx == dspwg_pkg::GAIN_LAST;
  endsequence
  sequence dmMidDone;
    s_r.st == S_DMW && fin && s_r.cnt != dspwg_pkg::DM_LAST_CNT;
  endsequence
  sequence dmReissue;
    s_r.st == S_DMW && !s_r.xStart ##1 s_r.xStart && s_r.xAddr == s_r.dmAddr;
  endsequence

  gains_then_run_a: assert property (gainLastDone |=> s_r.st == S_RUN)
    else $error("run not started right after the last gain");
  dm_triple_a: assert property (dmMidDone |=> dmReissue)
    else $error("data memory word not rewritten");
  run_go_a: assert property (s_r.st == S_RUN && s_r.xStart |->
    s_r.xAddr == dspwg_pkg::RUN_ADDR && s_r.xData[15:0] == dspwg_pkg::RUN_GO)
    else $error("start write has wrong value");
  stop_value_a: assert property (s_r.st == S_STOP && fin |=>
    !s_r.running && s_r.halted)
    else $error("stop not recorded");
  ack_issue_a: assert property (s_r.st == S_IDLE && !cmdValid && !firstRequestPin_n |=>
    ##1 s_r.xStart && s_r.xAddr == dspwg_pkg::STATUS_ADDR
    && s_r.xData == dspwg_pkg::DONE_MASK)
    else $error("done flag not acknowledged");
  key_before_ctl_a: assert property (s_r.xStart && s_r.xAddr == dspwg_pkg::CTL_ADDR |->
    s_r.prevAddr == dspwg_pkg::KEY_ADDR)
    else $error("control write without key");
  prot_on_a: assert property (s_r.st == S_CTL && fin && s_r.protTgt |=>
    s_r.prot && s_r.st != S_CTL)
    else $error("protection not tracked on");
  prot_off_a: assert property (s_r.st == S_CTL && fin && !s_r.protTgt |=>
    !s_r.prot)
    else $error("protection not tracked off");
  no_prot_write_a: assert property (s_r.xStart && s_r.xWr && inDm(s_r.xAddr) |->
    !s_r.prot)
    else $error("write issued into protected memory");
  energy_read_a: assert property (s_r.st == S_ENRD && s_r.xStart |->
    !s_r.xWr && s_r.xSize == dspwg_pkg::SZ32)
    else $error("energy access is not a read");
  cfg_clear_a: assert property (s_r.st == S_CFG && s_r.xStart |->
    (s_r.xData[15:0] & dspwg_pkg::PD_MASK) == 16'h0000)
    else $error("pulse disable bits left set");
  lowpower_stop_a: assert property (s_r.st == S_IDLE && !cmdValid && firstRequestPin_n
    && lowPowerReq && s_r.running |=> s_r.st == S_STOP)
    else $error("no stop on low power request");
  halted_dm_a: assert property (s_r.st == S_IDLE && cmdValid
    && cmdOp == dspwg_pkg::OP_DMWRITE && s_r.halted |=> s_r.err && s_r.st == S_IDLE)
    else $error("memory write accepted while halted");
endmodule // dspwg_host

`default_nettype wire

// >>> dspwg_pkg.sv
// constants shared by the host-side run and write-guard controller
// assumes the measurement device exposes one whole register per address behind dspwg_xfer
`default_nettype none

package dspwg_pkg;
  // ==========================================================
  // guarded data memory
  localparam logic [15:0] DM_FIRST    = 16'h4380;
  localparam logic [15:0] DM_LAST     = 16'h43BE;
  localparam int          DM_BITS     = 28;
  localparam int          DM_REPEAT   = 3;
  localparam logic [1:0]  DM_LAST_CNT = 2'(DM_REPEAT - 1);
  localparam logic [3:0]  DM_PAD      = 4'h0;
  // ==========================================================
  // write guard
  localparam logic [15:0] KEY_ADDR   = 16'hE7FE;
  localparam logic [15:0] CTL_ADDR   = 16'hE7E3;
  localparam logic [7:0]  KEY_VAL    = 8'hAD;
  localparam logic [7:0]  CTL_PROT   = 8'h80;
  localparam logic [7:0]  CTL_UNPROT = 8'h00;
  // ==========================================================
  // device registers without a fixed map here
  localparam logic [15:0] RUN_ADDR    = 16'hE228;
  localparam logic [15:0] STATUS_ADDR = 16'hE502;
  localparam logic [15:0] MASK_ADDR   = 16'hE50A;
  localparam logic [15:0] CFG_ADDR    = 16'hE610;
  localparam logic [15:0] RMSA_ADDR   = 16'h43C0;
  localparam logic [3:0][15:0] GAIN_ADDR = {16'h4383, 16'h4382, 16'h4381, 16'h4380};
  localparam logic [4:0][15:0] ENERGY_ADDR =
    {16'hE404, 16'hE403, 16'hE402, 16'hE401, 16'hE400};
  localparam logic [2:0]  GAIN_LAST   = 3'h3;
  localparam logic [2:0]  ENERGY_LAST = 3'h4;
  // ==========================================================
  // field values
  localparam logic [15:0] RUN_GO    = 16'h0001;
  localparam logic [15:0] RUN_HALT  = 16'h0000;
  localparam int          DONE_BIT  = 17;
  localparam logic [31:0] DONE_MASK = 32'h1 << DONE_BIT;
  localparam logic [15:0] PD_MASK   = 16'h0E00;
  localparam int          RMS_BITS  = 24;
  // ==========================================================
  // transfer widths
  localparam logic [1:0] SZ8  = 2'h0;
  localparam logic [1:0] SZ16 = 2'h1;
  localparam logic [1:0] SZ32 = 2'h2;

  typedef enum logic [2:0] {
    OP_INIT, OP_START, OP_STOP, OP_DMWRITE, OP_READ, OP_PROTECT, OP_UNPROTECT
  } dspwg_op_e;
endpackage

`default_nettype wire

// >>> dspwg_tb.sv
// self-checking bench for the host controller driving the device model
// assumes the package, interface, controller and device model are compiled first
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    dspwg_pkg::dspwg_op_e op;
    logic [15:0]          addr;
    logic [31:0]          data;
    logic [3:0]           dly;
    logic                 err;
    logic                 run;
    logic                 prot;
  } dspwg_row_s;
  logic                 ref_clk, arst_n, cmdValid, lowPowerReq, cmdReady, cmdDone, cmdErr;
  logic                 dataReady, running, protOn, regReq, regWr, regAck, firstRequestPin_n;
  dspwg_pkg::dspwg_op_e cmdOp;
  logic [15:0]          cmdAddr, cfModeVal, regAddr;
  logic [31:0]          cmdData, rdData, regWdata, regRdata;
  logic [3:0][27:0]     gainVal;
  logic [23:0]          phaseACurrentRms;
  logic [1:0]           regSize;
  logic [3:0]           ackDelay;
  dspwg_row_s           rows [0:15];
  int                   n_errors, samples_checked, k;

  dspwg_host DUT (.ref_clk, .arst_n, .cmdValid, .cmdOp, .cmdAddr, .cmdData, .gainVal,
    .cfModeVal, .lowPowerReq, .cmdReady, .cmdDone, .cmdErr, .rdData, .phaseACurrentRms,
    .dataReady, .running, .protOn, .regReq, .regWr, .regSize, .regAddr, .regWdata,
    .regAck, .regRdata, .firstRequestPin_n);
  dspwg_dev_model #(.PASS_CYC(400)) dev (.ref_clk, .arst_n, .ackDelay, .regReq, .regWr,
    .regSize, .regAddr, .regWdata, .regAck, .regRdata, .firstRequestPin_n);

  always #10 ref_clk = ~ref_clk;

  // ==========================================================
  // compare, wait and closing tasks
  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    chkWord({31'h0, got}, {31'h0, exp});
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a hang counts as a mismatch and ends the run
  task automatic step();
    @(negedge ref_clk);
    k++;
    if (k > 3000) begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic doCmd(input dspwg_row_s r);
    k = 0;
    while (cmdReady !== 1'b1) step();
    {cmdValid, cmdOp, cmdAddr, cmdData, ackDelay} = {1'b1, r.op, r.addr, r.data, r.dly};
    step();
    cmdValid = 1'b0;
    while (cmdDone !== 1'b1 && cmdErr !== 1'b1) step();
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {ref_clk, arst_n, cmdValid, lowPowerReq, n_errors, samples_checked} = '0;
    {cmdOp, cmdAddr, cmdData, ackDelay} = {dspwg_pkg::OP_READ, 16'h0, 32'h0, 4'h1};
    gainVal = {28'h0444444, 28'h0333333, 28'h0222222, 28'h0111111};
    cfModeVal = 16'hFFFF;
    rows = '{
      '{dspwg_pkg::OP_READ, 16'h4380, 32'h0, 4'h1, 1'h0, 1'h0, 1'h0},
      '{dspwg_pkg::OP_INIT, 16'h4390, 32'h0ABCDEF1, 4'h1, 1'h0, 1'h1, 1'h1},
      '{dspwg_pkg::OP_DMWRITE, 16'h4391, 32'h5, 4'h1, 1'h1, 1'h1, 1'h1},
      '{dspwg_pkg::OP_READ, 16'h4390, 32'h0ABCDEF1, 4'h5, 1'h0, 1'h1, 1'h1},
      '{dspwg_pkg::OP_START, 16'h0, 32'h0, 4'h1, 1'h1, 1'h1, 1'h1},
      '{dspwg_pkg::OP_UNPROTECT, 16'h0, 32'h0, 4'h3, 1'h0, 1'h1, 1'h0},
      '{dspwg_pkg::OP_DMWRITE, 16'h43BE, 32'h0FFFFFFF, 4'h5, 1'h0, 1'h1, 1'h0},
      '{dspwg_pkg::OP_READ, 16'h43BE, 32'h0FFFFFFF, 4'h0, 1'h0, 1'h1, 1'h0},
      '{dspwg_pkg::dspwg_op_e'(3'h7), 16'h0, 32'h0, 4'h1, 1'h1, 1'h1, 1'h0},
      '{dspwg_pkg::OP_DMWRITE, 16'h43BF, 32'h1, 4'h1, 1'h1, 1'h1, 1'h0},
      '{dspwg_pkg::OP_STOP, 16'h0, 32'h0, 4'h1, 1'h0, 1'h0, 1'h0},
      '{dspwg_pkg::OP_DMWRITE, 16'h4380, 32'h1, 4'h1, 1'h1, 1'h0, 1'h0},
      '{dspwg_pkg::OP_START, 16'h0, 32'h0, 4'h1, 1'h0, 1'h1, 1'h0},
      '{dspwg_pkg::OP_INIT, 16'h4390, 32'h1, 4'h1, 1'h1, 1'h1, 1'h0},
      '{dspwg_pkg::OP_PROTECT, 16'h0, 32'h0, 4'h2, 1'h0, 1'h1, 1'h1},
      '{dspwg_pkg::OP_READ, 16'hE530, 32'h00033316, 4'h1, 1'h0, 1'h1, 1'h1}};
    repeat (5) @(negedge ref_clk);
    chkBit(cmdReady, 1'h0);
    chkBit(running, 1'h0);
    arst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    foreach (rows[i]) begin
      doCmd(rows[i]);
      chkBit(cmdErr, rows[i].err);
      chkBit(running, rows[i].run);
      chkBit(protOn, rows[i].prot);
      if (rows[i].op == dspwg_pkg::OP_READ) chkWord(rdData, rows[i].data);
      if (i == 1) begin
        for (int g = 0; g < 4; g++) chkWord({4'h0, dev.dm[g]}, {4'h0, gainVal[g]});
        chkWord({16'h0, dev.run}, 32'h1);
        chkWord({16'h0, dev.cfg}, 32'hF1FF);
        chkBit(dev.mask[17], 1'h1);
        chkBit(dev.prot, 1'h1);
      end
    end
    // a done event: pin falls, host acknowledges and fetches the result
    k = 0;
    while (firstRequestPin_n !== 1'b0) step();
    chkBit(firstRequestPin_n, 1'h0);
    while (dataReady !== 1'b1) step();
    chkWord({8'h0, phaseACurrentRms}, 32'h3FF6A6);
    chkBit(firstRequestPin_n, 1'h1);
    // leaving normal power stops the processor
    lowPowerReq = 1'b1;
    k = 0;
    while (running !== 1'b0) step();
    chkWord({16'h0, dev.run}, 32'h0);
    lowPowerReq = 1'b0;
    // second reset after the stop clears guard and memory
    arst_n = 1'b0;
    @(negedge ref_clk);
    chkBit(protOn, 1'h0);
    chkBit(dev.prot, 1'h0);
    chkWord({4'h0, dev.dm[16]}, 32'h0);
    arst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    chkBit(cmdReady, 1'h1);
    test_done();
  end
endmodule // tb

`default_nettype wire

// >>> dspwg_xfer.sv
// drives the device register port for one transfer at a time
// assumes regAck arrives only while regReq is high
`default_nettype none

module dspwg_xfer (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  dspwg_acc_if.drv         acc,
  output var  logic        regReq,
  output var  logic        regWr,
  output var  logic [1:0]  regSize,
  output var  logic [15:0] regAddr,
  output var  logic [31:0] regWdata,
  input  wire logic        regAck,
  input  wire logic [31:0] regRdata
);
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [1:0]  size;
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        done;
    logic [31:0] rdata;
  } dspwg_xfer_s;

  dspwg_xfer_s s_r, s_nxt;

  // ==========================================================
  // request held until the device acknowledges
  always_comb begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    if (acc.start) begin
      s_nxt.req   = 1'b1;
      s_nxt.wr    = acc.wr;
      s_nxt.size  = acc.size;
      s_nxt.addr  = acc.addr;
      s_nxt.wdata = acc.wdata;
    end else if (s_r.req && regAck) begin
      s_nxt.req   = 1'b0;
      s_nxt.done  = 1'b1;
      s_nxt.rdata = regRdata;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign regReq    = s_r.req;
  assign regWr     = s_r.wr;
  assign regSize   = s_r.size;
  assign regAddr   = s_r.addr;
  assign regWdata  = s_r.wdata;
  assign acc.done  = s_r.done;
  assign acc.rdata = s_r.rdata;
endmodule // dspwg_xfer

`default_nettype wire
